// [inc/cdt_if.sv]
// register port and open-drain interrupt line between host and device
`timescale 1ns/100ps
`default_nettype none
interface cdt_if;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       irq_o;
    logic       irq_oe;
    wire        irq_n;

    // pulled high unless the device pulls it down
    assign irq_n = irq_oe ? irq_o : 1'b1;

    modport dev (input addr, input wdata, input wr, input rd,
                 output rdata, output irq_o, output irq_oe);
    modport host (output addr, output wdata, output wr, output rd,
                  input rdata, input irq_n);
endinterface : cdt_if
`default_nettype wire

// [inc/cdt_map.svh]
// offsets, field positions, reset values and timing counts of the timer block
`ifndef CDT_MAP_SVH
`define CDT_MAP_SVH

// ********************************************************************
// device register offsets
// ********************************************************************
`define CDT_OFS_CTRL      6'h00
`define CDT_OFS_IRQ_EN    6'h01
`define CDT_OFS_IRQ_FLAGS 6'h02
`define CDT_OFS_ALARM0    6'h10
`define CDT_OFS_CNT_LO    6'h18
`define CDT_OFS_CNT_HI    6'h19

// ********************************************************************
// field positions and reset values
// ********************************************************************
`define CDT_CTRL_RUN      1
`define CDT_CTRL_RELOAD   2
`define CDT_CTRL_SEL_LO   5
`define CDT_CTRL_SEL_HI   6
`define CDT_IRQ_ALARM     0
`define CDT_IRQ_TIMER     1
`define CDT_ALARM_EN_BIT  7
`define CDT_CTRL_RST      8'h00
`define CDT_IRQ_EN_RST    5'h00

// ********************************************************************
// timing: base tick of 64 Hz derived from the 50 MHz clock
// ********************************************************************
`define CDT_CLK_HZ        50000000
`define CDT_BASE_HZ       64
`define CDT_BASE_CYC      (`CDT_CLK_HZ / `CDT_BASE_HZ)

// ********************************************************************
// host bridge register indices (AXI4-Lite address bits 3:2, not byte addresses)
// ********************************************************************
`define CDT_AXI_CMD       2'h0
`define CDT_AXI_STATUS    2'h1
`define CDT_CMD_WRITE     16

`endif

// [inc/cdt_pkg.sv]
// types shared by the timer device and its host controller
package cdt_pkg;

    // host sequencing states, one-hot
    typedef enum logic [2:0] {
        CDT_IDLE  = 3'b001,
        CDT_ISSUE = 3'b010,
        CDT_FETCH = 3'b100
    } cdt_host_state_t;

    // whole state of the device end
    typedef struct packed {
        logic [19:0]      pre;
        logic [6:0]       base;
        logic             run;
        logic             reload_mode;
        logic [1:0]       src_sel;
        logic [4:0]       irq_en;
        logic [1:0]       flags;
        logic [15:0]      cnt_load;
        logic [15:0]      cnt;
        logic             reloading;
        logic             done;
        logic             match;
        logic [7:0]       rdata;
        logic [6:0][7:0]  alarm;
    } cdt_dev_st_t;

    // whole state of the host end
    typedef struct packed {
        cdt_host_state_t  state;
        logic             aw_have;
        logic             w_have;
        logic [1:0]       aw_idx;
        logic [31:0]      wdata;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic [16:0]      cmd;
        logic [7:0]       rsp;
        logic             irq_seen;
    } cdt_host_st_t;

endpackage : cdt_pkg

// [logic/cdt_rtc_dev.sv]
// countdown timer and alarm interrupt logic of the clock device
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"
module cdt_rtc_dev
    import cdt_pkg::*;
#(
    parameter int unsigned BASE_CYC = `CDT_BASE_CYC
)(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    cdt_if.dev                    link,
    input  wire logic [6:0][7:0]  time_now
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // base ticks (64 Hz) per source tick, minus one, as a mask
    function automatic logic [6:0] src_mask(input logic [1:0] sel);
        case (sel)
            2'b00:   src_mask = 7'h01;
            2'b01:   src_mask = 7'h07;
            2'b10:   src_mask = 7'h3f;
            2'b11:   src_mask = 7'h7f;
            default: src_mask = 7'h01;
        endcase
    endfunction : src_mask

    cdt_dev_st_t q;
    cdt_dev_st_t d;
    logic [6:0]  fld_hit;
    logic [6:0]  fld_on;

    // ****************************************************************
    // alarm field compare
    // ****************************************************************
    // enable bit per field, compare value
    for (genvar i = 0; i < 7; i++) begin : g_fld
        assign fld_on[i]  = q.alarm[i][`CDT_ALARM_EN_BIT];
        assign fld_hit[i] = !fld_on[i] ||
                            (q.alarm[i][6:0] == time_now[i][6:0]);
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic base_tick;
        logic src_tick;
        logic expire;
        logic match_now;
        base_tick = 1'b0;
        src_tick  = 1'b0;
        expire    = 1'b0;
        match_now = 1'b0;
        d = q;

        // 64 Hz base from the bus clock, then divided per select
        base_tick = (q.pre == 20'(BASE_CYC - 1));
        d.pre = base_tick ? 20'h00000 : q.pre + 20'h00001;
        if (base_tick) begin
            d.base = q.base + 7'h01;
        end
        src_tick = base_tick && ((q.base & src_mask(q.src_sel)) == 7'h00);

        // countdown engine
        if (!q.run) begin
            d.cnt       = q.cnt_load;
            d.reloading = 1'b0;
            d.done      = 1'b0;
        end else if (src_tick && !q.done) begin
            if (q.reloading) begin
                // reload takes one extra source clock
                d.cnt       = q.cnt_load;
                d.reloading = 1'b0;
            end else if (q.cnt != 16'h0000) begin
                // one step per source clock, zero stays put
                d.cnt = q.cnt - 16'h0001;
                if (q.cnt == 16'h0001) begin
                    expire = 1'b1;
                    d.reloading = q.reload_mode;
                    d.done = !q.reload_mode;
                end
            end
        end

        // all enabled fields together, and at least one enabled
        // logical and of the enabled compares
        match_now = (&fld_hit) && (|fld_on);
        d.match   = match_now;

        // register writes; a zero written to a flag clears it
        if (link.wr) begin
            case (link.addr)
                `CDT_OFS_CTRL: begin
                    d.run = link.wdata[`CDT_CTRL_RUN];
                    // select and reload frozen while running
                    if (!q.run) begin
                        d.reload_mode = link.wdata[`CDT_CTRL_RELOAD];
                        d.src_sel = link.wdata[`CDT_CTRL_SEL_HI:
                                               `CDT_CTRL_SEL_LO];
                    end
                end
                `CDT_OFS_IRQ_EN:    d.irq_en = link.wdata[4:0];
                `CDT_OFS_IRQ_FLAGS: d.flags = q.flags & link.wdata[1:0];
                // bytes only while stopped and no reload
                `CDT_OFS_CNT_LO: begin
                    if (!q.run && !q.reload_mode) begin
                        d.cnt_load[7:0] = link.wdata;
                    end
                end
                `CDT_OFS_CNT_HI: begin
                    if (!q.run && !q.reload_mode) begin
                        d.cnt_load[15:8] = link.wdata;
                    end
                end
                default: begin
                    if (link.addr >= `CDT_OFS_ALARM0 &&
                        link.addr < `CDT_OFS_ALARM0 + 6'h07) begin
                        d.alarm[3'(link.addr - `CDT_OFS_ALARM0)] =
                            link.wdata;
                    end
                end
            endcase
        end

        // hardware sets beat a same-cycle software clear
        // timer flag only with its enable
        if (expire && q.irq_en[`CDT_IRQ_TIMER]) begin
            d.flags[`CDT_IRQ_TIMER] = 1'b1;
        end
        // rising match only, gated by alarm enable
        if (match_now && !q.match && q.irq_en[`CDT_IRQ_ALARM]) begin
            d.flags[`CDT_IRQ_ALARM] = 1'b1;
        end

        // read data registered, answers the cycle after rd
        d.rdata = 8'h00;
        if (link.rd) begin
            case (link.addr)
                `CDT_OFS_CTRL: begin
                    d.rdata[`CDT_CTRL_RUN]    = q.run;
                    d.rdata[`CDT_CTRL_RELOAD] = q.reload_mode;
                    d.rdata[`CDT_CTRL_SEL_HI:`CDT_CTRL_SEL_LO] = q.src_sel;
                end
                `CDT_OFS_IRQ_EN:    d.rdata = {3'h0, q.irq_en};
                `CDT_OFS_IRQ_FLAGS: d.rdata = {6'h00, q.flags};
                `CDT_OFS_CNT_LO:    d.rdata = q.cnt_load[7:0];
                `CDT_OFS_CNT_HI:    d.rdata = q.cnt_load[15:8];
                default: begin
                    if (link.addr >= `CDT_OFS_ALARM0 &&
                        link.addr < `CDT_OFS_ALARM0 + 6'h07) begin
                        d.rdata = q.alarm[3'(link.addr - `CDT_OFS_ALARM0)];
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign link.rdata = q.rdata;
    // line held low while an enabled flag stands
    assign link.irq_o  = 1'b0;
    assign link.irq_oe = |(q.flags & q.irq_en[1:0]);

endmodule : cdt_rtc_dev
`default_nettype wire

// [logic/cdt_rtc_host.sv]
// host controller: AXI4-Lite command registers driving the device port
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"
module cdt_rtc_host
    import cdt_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    cdt_if.host               link,
    input  wire logic [3:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [3:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready
);

    cdt_host_st_t q;
    cdt_host_st_t d;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.irq_seen = !link.irq_n;
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.aw_idx  = s_axi_awaddr[3:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        // write completes once address and data are both held
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = 2'b00;
            if (q.aw_idx == `CDT_AXI_CMD) begin
                // a command while busy is dropped, not queued
                if (q.state == CDT_IDLE && (&s_axi_wstrb[2:0] || 1'b1)) begin
                    d.cmd   = q.wdata[16:0];
                    d.state = CDT_ISSUE;
                end
            end else if (q.aw_idx != `CDT_AXI_STATUS) begin
                d.bresp = 2'b10;
            end
        end
        // device port sequencing
        case (q.state)
            CDT_IDLE:  d.state = d.state;
            CDT_ISSUE: d.state = CDT_FETCH;
            CDT_FETCH: begin
                if (!q.cmd[`CDT_CMD_WRITE]) begin
                    d.rsp = link.rdata;
                end
                d.state = CDT_IDLE;
            end
            default:   d.state = CDT_IDLE;
        endcase
        // read channel
        if (s_axi_rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = 2'b00;
            case (s_axi_araddr[3:2])
                `CDT_AXI_CMD:    d.rdata = {15'h0000, q.cmd};
                `CDT_AXI_STATUS: d.rdata = {16'h0000, q.rsp, 6'h00,
                                            q.irq_seen,
                                            q.state != CDT_IDLE};
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = 2'b10;
                end
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q       <= '0;
            q.state <= CDT_IDLE;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign s_axi_awready = !q.aw_have && !q.bvalid;
    assign s_axi_wready  = !q.w_have && !q.bvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    // one-cycle strobe toward the device
    assign link.addr  = q.cmd[13:8];
    assign link.wdata = q.cmd[7:0];
    assign link.wr    = (q.state == CDT_ISSUE) && q.cmd[`CDT_CMD_WRITE];
    assign link.rd    = (q.state == CDT_ISSUE) && !q.cmd[`CDT_CMD_WRITE];

endmodule : cdt_rtc_host
`default_nettype wire

// [verification/cdt_rtc_monitor.sv]
// assertions on the register port and interrupt line of the timer block
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"
module cdt_rtc_monitor
    import cdt_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [7:0]  rdata,
    input  wire logic        irq_o,
    input  wire logic        irq_oe,
    input  wire logic        irq_n
);
    // ********************************
    // shadow of what software wrote
    // ********************************
    typedef struct packed {
        logic [4:0] en;
        logic       run;
        logic       rl;
        logic [1:0] sel;
        logic [7:0] lo;
        logic [7:0] hi;
    } cdt_mon_st_t;
    cdt_mon_st_t st_q;
    cdt_mon_st_t st_d;
    logic        stopped;

    // mode bits and count bytes freeze while the timer runs
    assign stopped = !st_q.run && !st_q.rl;
    always_comb begin
        st_d = st_q;
        if (wr && addr == `CDT_OFS_IRQ_EN) st_d.en = wdata[4:0];
        if (wr && addr == `CDT_OFS_CTRL) st_d.run = wdata[1];
        if (wr && addr == `CDT_OFS_CTRL && !st_q.run) begin
            st_d.rl  = wdata[2];
            st_d.sel = wdata[6:5];
        end
        if (wr && addr == `CDT_OFS_CNT_LO && stopped) st_d.lo = wdata;
        if (wr && addr == `CDT_OFS_CNT_HI && stopped) st_d.hi = wdata;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_en_readback: assert property (
        rd && addr == `CDT_OFS_IRQ_EN |=> rdata == {3'b000, $past(st_q.en)})
        else $error("enable register read back wrong");
    chk_flag_hi_zero: assert property (
        rd && addr == `CDT_OFS_IRQ_FLAGS |=> rdata[7:5] == 3'b000)
        else $error("flag register top bits not zero");
    chk_cnt_lo_hold: assert property (
        rd && addr == `CDT_OFS_CNT_LO && stopped |=>
            rdata == $past(st_q.lo))
        else $error("count low byte wrong");
    chk_cnt_hi_hold: assert property (
        rd && addr == `CDT_OFS_CNT_HI && stopped |=>
            rdata == $past(st_q.hi))
        else $error("count high byte wrong");
    chk_ctrl_frozen: assert property (
        rd && addr == `CDT_OFS_CTRL |=>
            rdata[6:5] == $past(st_q.sel) && rdata[2] == $past(st_q.rl))
        else $error("mode bits changed while running");
    chk_pull_low: assert property (
        irq_oe |-> irq_o == 1'b0)
        else $error("interrupt line driven high");
    chk_irq_release: assert property (
        wr && addr == `CDT_OFS_IRQ_EN && wdata[1:0] == 2'b00 |->
            ##[1:2] !irq_oe)
        else $error("interrupt kept after enables cleared");
    chk_fall_by_write: assert property (
        $fell(irq_oe) |-> $past(wr) || $past(wr, 2))
        else $error("interrupt dropped without a write");
    chk_irq_needs_en: assert property (
        irq_oe |-> st_q.en[1:0] != 2'b00 || $past(st_q.en[1:0]) != 2'b00)
        else $error("interrupt with both enables clear");

    cov_irq_low: cover property ($rose(irq_oe));
    cov_locked_wr: cover property (wr && addr == `CDT_OFS_CNT_LO && st_q.run);
    cov_flag_clr: cover property (wr && addr == `CDT_OFS_IRQ_FLAGS && irq_oe);
endmodule : cdt_rtc_monitor
`default_nettype wire

// [verification/tb_countdown_timer_alarm_irq.sv]
// bench joining host and device ends, driven over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"
module tb_countdown_timer_alarm_irq;
    localparam int BASE  = 4;          // short base tick keeps the run brief
    localparam int TICK  = 2 * BASE;   // 32 Hz source period in clocks
    localparam int LIMIT = 20000;
    typedef struct packed {
        logic [5:0] off;
        logic [7:0] wd;
        logic [7:0] mask;
        logic [7:0] exp;
    } cdt_row_t;
    // offset, written, read mask, expected read
    localparam cdt_row_t ROWS [8] = '{
        '{6'h01, 8'hff, 8'hff, 8'h1f}, '{6'h01, 8'h00, 8'hff, 8'h00},
        '{6'h02, 8'hff, 8'hff, 8'h00}, '{6'h18, 8'ha5, 8'hff, 8'ha5},
        '{6'h19, 8'h3c, 8'hff, 8'h3c}, '{6'h00, 8'h64, 8'h66, 8'h64},
        '{6'h00, 8'h00, 8'h66, 8'h00}, '{6'h3f, 8'h55, 8'hff, 8'h00}};
    logic             aclk;
    logic             aresetn = 1'b0;
    logic [3:0]       awaddr = 4'h0, araddr = 4'h0;
    logic [31:0]      wdata = 32'h0;
    logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic             arvalid = 1'b0, rready = 1'b0;
    logic             awready, wready, bvalid, arready, rvalid;
    logic [1:0]       bresp, rresp, r;
    logic [31:0]      rdata, st;
    logic [6:0][7:0]  time_now = '0;
    logic [7:0]       q;
    logic             irq_prev = 1'b1;
    int               cyc = 0, t_run = 0, t_irq = 0, t0, t1;
    int               miscompares = 0, check_count = 0;

    cdt_if link_if();
    cdt_rtc_dev #(.BASE_CYC(BASE)) cdt_rtc_dev_inst (.aclk(aclk),
        .aresetn(aresetn), .link(link_if), .time_now(time_now));
    cdt_rtc_host cdt_rtc_host_inst (.aclk(aclk), .aresetn(aresetn),
        .link(link_if), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cdt_rtc_monitor cdt_rtc_monitor_inst (.aclk(aclk), .aresetn(aresetn),
        .addr(link_if.addr), .wdata(link_if.wdata), .wr(link_if.wr),
        .rd(link_if.rd), .rdata(link_if.rdata), .irq_o(link_if.irq_o),
        .irq_oe(link_if.irq_oe), .irq_n(link_if.irq_n));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // cycle stamps of control writes and interrupt falls, plus the timeout
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        irq_prev <= link_if.irq_n;
        if (link_if.wr && link_if.addr == `CDT_OFS_CTRL) t_run <= cyc;
        if (irq_prev === 1'b1 && link_if.irq_n === 1'b0) t_irq <= cyc;
        if (cyc == LIMIT) begin
            $display("wrong value at %0t: timeout", $time);
            miscompares++;
            finish_test();
        end
    end

    // ********************************
    // bus tasks
    // ********************************
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                             output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                            output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : axi_read
    // one device access through the command register, polled until idle
    task automatic dev_access(input logic w, input logic [5:0] off,
                              input logic [7:0] d, output logic [7:0] rb);
        logic [31:0] s;
        logic [1:0]  rs;
        int          n;
        axi_write(4'h0, {15'h0000, w, 2'b00, off, d}, rs);
        s = 32'h1;
        n = 0;
        while (s[0] !== 1'b0 && n < 50) begin
            axi_read(4'h4, s, rs);
            n++;
        end
        rb = s[15:8];
    endtask : dev_access
    task automatic wait_irq();
        int n;
        n = 0;
        while (link_if.irq_n !== 1'b0 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        @(posedge aclk);
    endtask : wait_irq

    // ********************************
    // comparisons and verdict
    // ********************************
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic cmp_pin(input logic exp);
        check_count++;
        if (link_if.irq_n !== exp) begin
            miscompares++;
            $display("wrong value at %0t: interrupt line", $time);
        end
    endtask : cmp_pin
    task automatic cmp_span(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: span %0d", $time, got);
        end
    endtask : cmp_span
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ROWS[i]) begin
            dev_access(1'b1, ROWS[i].off, ROWS[i].wd, q);
            dev_access(1'b0, ROWS[i].off, 8'h00, q);
            cmp_byte(q & ROWS[i].mask, ROWS[i].exp);
        end
        // unmapped bridge addresses answer with a slave error
        axi_write(4'h8, 32'h0, r);
        cmp_byte({6'h00, r}, 8'h02);
        axi_read(4'hc, st, r);
        cmp_byte({6'h00, r}, 8'h02);
        // one-shot of three source ticks, with locked writes meanwhile
        dev_access(1'b1, 6'h18, 8'h03, q);
        dev_access(1'b1, 6'h19, 8'h00, q);
        dev_access(1'b1, 6'h01, 8'h02, q);
        dev_access(1'b1, 6'h00, 8'h02, q);
        t0 = t_run;
        dev_access(1'b1, 6'h18, 8'h77, q);
        dev_access(1'b1, 6'h00, 8'h66, q);
        dev_access(1'b0, 6'h18, 8'h00, q);
        cmp_byte(q, 8'h03);
        dev_access(1'b0, 6'h00, 8'h00, q);
        cmp_byte(q & 8'h66, 8'h02);
        wait_irq();
        cmp_span(t_irq - t0, 2 * TICK, 3 * TICK + 4);
        dev_access(1'b0, 6'h02, 8'h00, q);
        cmp_byte(q, 8'h02);
        dev_access(1'b1, 6'h02, 8'h00, q);
        cmp_pin(1'b1);
        repeat (100) @(posedge aclk);
        cmp_pin(1'b1);
        // auto-reload: later periods last n+1 ticks
        dev_access(1'b1, 6'h00, 8'h00, q);
        dev_access(1'b1, 6'h00, 8'h06, q);
        wait_irq();
        t1 = t_irq;
        dev_access(1'b1, 6'h02, 8'h00, q);
        wait_irq();
        cmp_span(t_irq - t1, 4 * TICK, 4 * TICK);
        dev_access(1'b1, 6'h00, 8'h00, q);
        dev_access(1'b0, 6'h00, 8'h00, q);
        cmp_byte(q & 8'h66, 8'h04);
        dev_access(1'b1, 6'h02, 8'h00, q);
        dev_access(1'b1, 6'h00, 8'h22, q);
        t0 = t_run;
        wait_irq();
        cmp_span(t_irq - t0, 8 * TICK + 2, 12 * TICK + 1);
        dev_access(1'b1, 6'h01, 8'h00, q);
        cmp_pin(1'b1);
        dev_access(1'b1, 6'h02, 8'h00, q);
        // alarm: minute field only, second field present but disabled
        time_now[1] <= 8'h44;
        dev_access(1'b1, 6'h01, 8'h01, q);
        dev_access(1'b1, 6'h10, 8'h07, q);
        dev_access(1'b1, 6'h11, 8'hc5, q);
        cmp_pin(1'b1);
        time_now[1] <= 8'h45;
        wait_irq();
        cmp_pin(1'b0);
        dev_access(1'b0, 6'h02, 8'h00, q);
        cmp_byte(q, 8'h01);
        dev_access(1'b1, 6'h02, 8'h00, q);
        repeat (20) @(posedge aclk);
        cmp_pin(1'b1);
        // hour field added: the minute match alone no longer suffices
        dev_access(1'b1, 6'h12, 8'h90, q);
        time_now[1] <= 8'h46;
        repeat (4) @(posedge aclk);
        time_now[1] <= 8'h45;
        repeat (20) @(posedge aclk);
        cmp_pin(1'b1);
        time_now[2] <= 8'h10;
        wait_irq();
        cmp_pin(1'b0);
        dev_access(1'b1, 6'h02, 8'h00, q);
        cmp_pin(1'b1);
        // alarm enable off: a fresh match leaves flag and line alone
        dev_access(1'b1, 6'h01, 8'h00, q);
        time_now[2] <= 8'h11;
        repeat (4) @(posedge aclk);
        time_now[2] <= 8'h10;
        repeat (20) @(posedge aclk);
        cmp_pin(1'b1);
        dev_access(1'b0, 6'h02, 8'h00, q);
        cmp_byte(q, 8'h00);
        // reset in mid-run with the line pulled low
        dev_access(1'b1, 6'h01, 8'h01, q);
        time_now[2] <= 8'h11;
        repeat (4) @(posedge aclk);
        time_now[2] <= 8'h10;
        wait_irq();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        cmp_pin(1'b1);
        dev_access(1'b0, 6'h01, 8'h00, q);
        cmp_byte(q, 8'h00);
        dev_access(1'b0, 6'h18, 8'h00, q);
        cmp_byte(q, 8'h00);
        finish_test();
    end
endmodule : tb_countdown_timer_alarm_irq
`default_nettype wire
